// ==== logic/sense_protect_cfg.svh ====
/*
 * Holds the addresses, field positions, reset values and widths of the
 * protected sense control block.
 * Assumes it is included by its bare name from the package and the design.
 */
`ifndef SENSE_PROTECT_CFG_SVH
`define SENSE_PROTECT_CFG_SVH

// Register addresses on the internal serial register link.
`define ADDR_CAL_CONTROL        8'h10
`define ADDR_SENSE_FIVE         8'h11
`define ADDR_SENSE_PROTECTED    8'h12

// Reset values of the stored registers.
`define RESET_SENSE_FIVE        8'h00
`define RESET_SENSE_PROTECTED   8'h40
`define RESET_BYTE_ZERO         8'h00

// Field positions.
`define BIT_CAL_START           0
`define BIT_WRITE_UNLOCK        5
`define BIT_OFFSET_SELECT       6
`define BIT_OVERRIDE_ENABLE     0

// Width of the register address and data.
`define REG_WIDTH               8

`endif

// ==== logic/sense_protect_pkg.sv ====
/*
 * Holds the types shared by the protected sense control block.
 * Assumes the configuration header sits in the include path.
 */
`include "sense_protect_cfg.svh"

package sense_protect_pkg;

    // One register address or data byte on the register link.
    typedef logic [`REG_WIDTH-1:0] reg_byte_t;

endpackage

// ==== logic/sense_control_protected_regs.sv ====
/*
 * Holds the write protected sense control register, its unlock register,
 * the calibration start bit, and the gate driver sleep logic.
 * Assumes a register decoder behind the internal serial link presents one
 * byte access per strobe, synchronous to ref_clk_i, and that the analog
 * calibration engine pulses cal_done_i for one cycle when it finishes.
 */
// What this block does
// - Protected register sits at 0x12 and resets to 0x40.
// - Writes to the protected register land only while the unlock bit is one.
// - Bit 6 selects offset source: zero calibration data, one factory trim.
// - Finished sensing amplifier calibration clears the offset source bit to zero.
// - Bit 0 enables gate driver active override mode, resetting to zero.
// - Controller reset releases its enable pin, pulled low, so the driver sleeps.
// - Unlock bit is bit 5 of register 0x11; one permits protected writes.
// - With sensing enabled, writing one to the calibration bit starts it; done clears it.
`include "sense_protect_cfg.svh"

module sense_control_protected_regs
    import sense_protect_pkg::*;
(
    input  wire logic      ref_clk_i,
    input  wire logic      rst_n_i,
    input  wire reg_byte_t reg_addr_i,
    input  wire reg_byte_t reg_wdata_i,
    input  wire logic      reg_wr_i,
    input  wire logic      reg_rd_i,
    output reg_byte_t      reg_rdata_o,
    output logic           reg_rvalid_o,
    input  wire logic      emf_sensing_enable_i,
    input  wire logic      cal_done_i,
    input  wire logic      mcu_reset_n_i,
    input  wire logic      driver_enable_port_oe_i,
    input  wire logic      driver_enable_port_out_i,
    output logic           emf_offset_source_select_o,
    output logic           gate_override_enable_o,
    output logic           emf_cal_run_o,
    output logic           amp3_cal_run_o,
    output logic           driver_enable_o,
    output logic           driver_sleep_o
);

    logic      rst_meta;
    logic      rst_n;
    reg_byte_t sense_control_five;
    reg_byte_t sense_control_protected;
    logic      amp3_or_emf_cal_start;
    reg_byte_t next_sense_control_five;
    reg_byte_t next_sense_control_protected;
    logic      next_amp3_or_emf_cal_start;
    reg_byte_t next_rdata;
    logic      next_rvalid;
    logic      next_emf_cal_run;
    logic      next_amp3_cal_run;
    logic      next_driver_enable;
    logic      protected_write_unlock;
    logic      emf_cal_finish;

    // Releases the reset through two flip-flops; only the second is used.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign protected_write_unlock = sense_control_five[`BIT_WRITE_UNLOCK];
    assign emf_cal_finish = cal_done_i & amp3_or_emf_cal_start & emf_sensing_enable_i;

    // Computes the next register contents from writes and calibration events.
    always_comb begin
        next_sense_control_five      = sense_control_five;
        next_sense_control_protected = sense_control_protected;
        next_amp3_or_emf_cal_start   = amp3_or_emf_cal_start;
        if (reg_wr_i && reg_addr_i == `ADDR_SENSE_FIVE) begin
            next_sense_control_five = reg_wdata_i;
        end
        // A locked write is dropped silently; an unlocked one stores all eight bits as written, except bit 6 in a calibration finish cycle.
        if (reg_wr_i && reg_addr_i == `ADDR_SENSE_PROTECTED && protected_write_unlock) begin
            next_sense_control_protected = reg_wdata_i;
        end
        // The hardware clear wins over a write in the same cycle.
        if (emf_cal_finish) begin
            next_sense_control_protected[`BIT_OFFSET_SELECT] = 1'b0;
        end
        if (cal_done_i) begin
            next_amp3_or_emf_cal_start = 1'b0;
        end
        // A start written in the clearing cycle is kept, so it is never lost.
        if (reg_wr_i && reg_addr_i == `ADDR_CAL_CONTROL && reg_wdata_i[`BIT_CAL_START]) begin
            next_amp3_or_emf_cal_start = 1'b1;
        end
    end

    // Registers the stored bits.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sense_control_five      <= `RESET_SENSE_FIVE;
            sense_control_protected <= `RESET_SENSE_PROTECTED;
            amp3_or_emf_cal_start   <= 1'b0;
        end else begin
            sense_control_five      <= next_sense_control_five;
            sense_control_protected <= next_sense_control_protected;
            amp3_or_emf_cal_start   <= next_amp3_or_emf_cal_start;
        end
    end

    // Selects the read data; unmapped addresses answer zero.
    always_comb begin
        next_rvalid = reg_rd_i;
        next_rdata  = `RESET_BYTE_ZERO;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_CAL_CONTROL: begin
                    next_rdata[`BIT_CAL_START] = amp3_or_emf_cal_start;
                end
                `ADDR_SENSE_FIVE: begin
                    next_rdata = sense_control_five;
                end
                `ADDR_SENSE_PROTECTED: begin
                    next_rdata = sense_control_protected;
                end
                default: begin
                    next_rdata = `RESET_BYTE_ZERO;
                end
            endcase
        end
    end

    // Computes calibration steering and the driver enable seen by the gate driver.
    always_comb begin
        next_emf_cal_run  = amp3_or_emf_cal_start & emf_sensing_enable_i;
        next_amp3_cal_run = amp3_or_emf_cal_start & ~emf_sensing_enable_i;
        // An undriven enable pin reads low through the pulldown.
        next_driver_enable = mcu_reset_n_i & driver_enable_port_oe_i
                             & driver_enable_port_out_i;
    end

    // Registers the read answer and the control outputs.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o     <= `RESET_BYTE_ZERO;
            reg_rvalid_o    <= 1'b0;
            emf_cal_run_o   <= 1'b0;
            amp3_cal_run_o  <= 1'b0;
            driver_enable_o <= 1'b0;
            driver_sleep_o  <= 1'b1;
        end else begin
            reg_rdata_o     <= next_rdata;
            reg_rvalid_o    <= next_rvalid;
            emf_cal_run_o   <= next_emf_cal_run;
            amp3_cal_run_o  <= next_amp3_cal_run;
            driver_enable_o <= next_driver_enable;
            driver_sleep_o  <= ~next_driver_enable;
        end
    end

    // The configuration bits leave straight from the stored register.
    assign emf_offset_source_select_o = sense_control_protected[`BIT_OFFSET_SELECT];
    assign gate_override_enable_o     = sense_control_protected[`BIT_OVERRIDE_ENABLE];

    // Describes the steps of locked and unlocked writes and calibration.
    sequence s_locked_write;
        reg_wr_i && reg_addr_i == `ADDR_SENSE_PROTECTED && !protected_write_unlock;
    endsequence

    sequence s_unlocked_write;
        reg_wr_i && reg_addr_i == `ADDR_SENSE_PROTECTED && protected_write_unlock;
    endsequence

    sequence s_cal_finish;
        amp3_or_emf_cal_start && cal_done_i && emf_sensing_enable_i;
    endsequence

    // Checks that the protected register comes out of reset at its reset value.
    a_reset_value_loaded: assert property (
        @(posedge ref_clk_i) $rose(rst_n) |-> sense_control_protected == `RESET_SENSE_PROTECTED
            && emf_offset_source_select_o && !gate_override_enable_o)
        else $error("Protected register did not reset to its reset value.");

    // Checks that a locked write leaves the register unchanged.
    a_locked_write_ignored: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        s_locked_write and !emf_cal_finish |=> $stable(sense_control_protected))
        else $error("Locked write changed the protected register.");

    // Checks that an unlocked write stores every bit, reserved ones included.
    a_unlocked_write_stored: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        s_unlocked_write and !emf_cal_finish |=> sense_control_protected == $past(reg_wdata_i))
        else $error("Unlocked write was not stored.");

    // Checks that finished sensing calibration selects calibration data.
    a_offset_cleared_cal: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        s_cal_finish and !(reg_wr_i && reg_addr_i == `ADDR_CAL_CONTROL
            && reg_wdata_i[`BIT_CAL_START])
            |=> !emf_offset_source_select_o && !amp3_or_emf_cal_start ##1 !emf_cal_run_o)
        else $error("Calibration finish did not clear the offset select.");

    // Checks that a start write launches sensing calibration two cycles after the write.
    a_cal_start_runs: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        reg_wr_i && reg_addr_i == `ADDR_CAL_CONTROL && reg_wdata_i[`BIT_CAL_START]
            && emf_sensing_enable_i ##1 emf_sensing_enable_i |=> emf_cal_run_o)
        else $error("Calibration start did not run sensing calibration.");

    // Checks that a read answers one cycle later with the current contents.
    a_read_returns_value: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        reg_rd_i && reg_addr_i == `ADDR_SENSE_PROTECTED
            |=> reg_rvalid_o && reg_rdata_o == $past(sense_control_protected))
        else $error("Protected register read returned wrong data.");

    // Checks that the unlock bit comes from bit 5 of the neighbouring register.
    a_unlock_from_five: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        reg_wr_i && reg_addr_i == `ADDR_SENSE_FIVE |=> protected_write_unlock
            == $past(reg_wdata_i[`BIT_WRITE_UNLOCK]))
        else $error("Unlock bit does not follow its register write.");

    // Checks that a controller reset puts the gate driver to sleep.
    a_sleep_mcu_reset: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        !mcu_reset_n_i |=> driver_sleep_o && !driver_enable_o)
        else $error("Controller reset did not put the driver to sleep.");

    // Checks that override mode follows bit 0 after an unlocked write.
    a_override_from_write: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        s_unlocked_write |=> gate_override_enable_o == $past(reg_wdata_i[`BIT_OVERRIDE_ENABLE]))
        else $error("Override enable does not follow bit 0.");

endmodule

// ==== tb/cal_engine_model.sv ====
/*
 * Models the far side: the calibration engine that answers a run request
 * and the controller pin that feeds the driver enable input.
 * Assumes one clock shared with the design and the bench's reset.
 */
module cal_engine_model
    import sense_protect_pkg::*;
#(
    parameter int CAL_CYCLES = 5
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic emf_cal_run_i,
    input  wire logic amp3_cal_run_i,
    input  wire logic mcu_reset_n_i,
    input  wire logic pin_drive_i,
    output logic      cal_done_o,
    output logic      port_oe_o,
    output logic      port_out_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    // Counts run cycles and pulses done once when the count is reached.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 0;
            cal_done_o <= 1'b0;
        end else begin
            cnt <= (emf_cal_run_i || amp3_cal_run_i) ? cnt + 1 : 0;
            cal_done_o <= (cnt == CAL_CYCLES - 1);
        end
    end

    // The pin is released in controller reset and then reads low through its pulldown.
    assign port_oe_o = mcu_reset_n_i;
    assign port_out_o = port_oe_o ? pin_drive_i : 1'b0;
endmodule

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the protected sense control registers.
 * Assumes the package and configuration header are compiled first.
 */
`include "sense_protect_cfg.svh"

module tb_top
    import sense_protect_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic      clk, rst_n, wr, rd, emf_en, cal_done, mcu_rst_n, oe, pout, pin_drive;
    logic      rvalid, offset_sel, override, emf_run, amp3_run, drv_en, drv_sleep;
    reg_byte_t addr, wdata, rdata;
    int        error_cnt, comparisons, i;

    sense_control_protected_regs u_dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .emf_sensing_enable_i(emf_en), .cal_done_i(cal_done), .mcu_reset_n_i(mcu_rst_n),
        .driver_enable_port_oe_i(oe), .driver_enable_port_out_i(pout),
        .emf_offset_source_select_o(offset_sel), .gate_override_enable_o(override),
        .emf_cal_run_o(emf_run), .amp3_cal_run_o(amp3_run),
        .driver_enable_o(drv_en), .driver_sleep_o(drv_sleep));

    cal_engine_model u_far (
        .ref_clk_i(clk), .rst_n_i(rst_n), .emf_cal_run_i(emf_run),
        .amp3_cal_run_i(amp3_run), .mcu_reset_n_i(mcu_rst_n), .pin_drive_i(pin_drive),
        .cal_done_o(cal_done), .port_oe_o(oe), .port_out_o(pout));

    // Free running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input reg_byte_t seen, input reg_byte_t exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One write strobe, taken at the rising edge between two falling edges.
    task automatic wr_reg(input reg_byte_t a, input reg_byte_t d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // One read strobe; the answer is registered at the taking edge and checked at the next falling edge.
    task automatic rd_reg(input reg_byte_t a, input reg_byte_t exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        check({7'h00, rvalid}, 8'h01);
        check(rdata, exp);
        rd = 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Main sequence: reset, lock, unlock, calibration, enable pin.
    initial begin
        {error_cnt, comparisons} = 0;
        {wr, rd, emf_en, mcu_rst_n, pin_drive, rst_n} = 6'h00;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (6) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check({6'h00, offset_sel, override}, 8'h02);
        check({7'h00, drv_sleep}, 8'h01);
        rd_reg(`ADDR_SENSE_PROTECTED, 8'h40);
        rd_reg(`ADDR_SENSE_FIVE, 8'h00);
        wr_reg(`ADDR_SENSE_PROTECTED, 8'h01);
        rd_reg(`ADDR_SENSE_PROTECTED, 8'h40);
        check({7'h00, override}, 8'h00);
        wr_reg(`ADDR_SENSE_FIVE, 8'h20);
        rd_reg(`ADDR_SENSE_FIVE, 8'h20);
        wr_reg(`ADDR_SENSE_PROTECTED, 8'h01);
        check({6'h00, offset_sel, override}, 8'h01);
        wr_reg(`ADDR_SENSE_PROTECTED, 8'h41);
        rd_reg(`ADDR_SENSE_PROTECTED, 8'h41);
        wr_reg(`ADDR_SENSE_FIVE, 8'h00);
        wr_reg(`ADDR_SENSE_PROTECTED, 8'h00);
        rd_reg(`ADDR_SENSE_PROTECTED, 8'h41);
        rd_reg(8'h33, 8'h00);
        wr_reg(`ADDR_CAL_CONTROL, 8'h01);
        idle(1);
        check({6'h00, amp3_run, emf_run}, 8'h02);
        idle(12);
        check({6'h00, amp3_run, offset_sel}, 8'h01);
        rd_reg(`ADDR_CAL_CONTROL, 8'h00);
        emf_en = 1'b1;
        wr_reg(`ADDR_CAL_CONTROL, 8'h01);
        idle(1);
        check({6'h00, amp3_run, emf_run}, 8'h01);
        for (i = 0; i < 20 && offset_sel !== 1'b0; i++) idle(1);
        if (i == 20) begin
            error_cnt++;
        end else begin
            idle(2);
            check({7'h00, emf_run}, 8'h00);
            rd_reg(`ADDR_SENSE_PROTECTED, 8'h01);
            rd_reg(`ADDR_CAL_CONTROL, 8'h00);
            mcu_rst_n = 1'b1;
            pin_drive = 1'b1;
            idle(3);
            check({6'h00, drv_en, drv_sleep}, 8'h02);
            mcu_rst_n = 1'b0;
            idle(3);
            check({6'h00, drv_en, drv_sleep}, 8'h01);
        end
        finish_test();
    end
endmodule
